//--- core/caf_filter_ids.v
`timescale 1ns/100ps
`default_nettype none
`include "caf_regs.vh"

module caf_filter_ids (
    input wire sys_clk_i,
    input wire resetn_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output reg [31:0] prdata_o,
    output reg pready_o,
    output reg pslverr_o,
    input wire rx_id_valid_i,
    input wire rx_id_extended_i,
    input wire [10:0] rx_std_id_i,
    input wire [17:0] rx_ext_id_i,
    output reg [15:0] filter_match_o,
    output reg match_valid_o
);

    reg [15:0] std_pattern_r [0:`CAF_NUM_FILTERS-1];
    reg [15:0] ext_pattern_r [0:`CAF_NUM_FILTERS-1];
    reg [1:0] ctrl_r;
    reg [10:0] last_std_r;
    reg [17:0] last_ext_r;
    reg last_xtd_r;
    reg [15:0] match_nxt;
    reg [31:0] rdata_nxt;
    reg addr_ok;
    wire [`CAF_IDX_W-1:0] idx;
    wire setup;
    wire access;
    integer i;

    assign idx = paddr_i[`CAF_IDX_W+1:2];
    // Zero-wait-state slave: answer in the cycle after setup
    assign setup = psel_i & ~penable_i;
    // Writes land only at the edge that completes the access phase
    assign access = psel_i & penable_i & pready_o;

    function sid_in_block;
        input [11:0] a;
        input [11:0] base;
        begin
            sid_in_block = ((a & `CAF_BLOCK_MASK) == base) && (a[1:0] == 2'h0);
        end
    endfunction

    // Pattern compare: standard bits always, extended bits only for extended frames, type bit only with type match on
    function filter_hit;
        input [15:0] standard_id_pattern_bits;
        input [15:0] extended_id_pattern_bits;
        input [10:0] rstd;
        input [17:0] rext;
        input rxtd;
        input type_en;
        reg std_ok;
        reg ext_ok;
        reg type_ok;
        begin
            std_ok = (standard_id_pattern_bits[`CAF_SID_HI:`CAF_SID_LO] == rstd);
            ext_ok = ({standard_id_pattern_bits[`CAF_SID_EXTHI_HI:`CAF_SID_EXTHI_LO], extended_id_pattern_bits} == rext);
            // Type select ignored while type match is off
            type_ok = ~type_en | (standard_id_pattern_bits[`CAF_SID_TYPE_BIT] == rxtd);
            filter_hit = std_ok & type_ok & (~rxtd | ext_ok);
        end
    endfunction

    always @* begin
        addr_ok = sid_in_block(paddr_i, `CAF_SID_BASE) | sid_in_block(paddr_i, `CAF_EID_BASE)
            | (paddr_i == `CAF_CTRL_ADDR) | (paddr_i == `CAF_RXSTD_ADDR)
            | (paddr_i == `CAF_RXEXT_ADDR) | (paddr_i == `CAF_MATCH_ADDR);
        rdata_nxt = 32'h0000_0000;
        if (sid_in_block(paddr_i, `CAF_SID_BASE)) begin
            rdata_nxt[15:0] = std_pattern_r[idx] & `CAF_SID_WMASK;
        end else if (sid_in_block(paddr_i, `CAF_EID_BASE)) begin
            rdata_nxt[15:0] = ext_pattern_r[idx];
        end else if (paddr_i == `CAF_CTRL_ADDR) begin
            rdata_nxt[1:0] = ctrl_r;
        end else if (paddr_i == `CAF_RXSTD_ADDR) begin
            rdata_nxt[11:0] = {last_xtd_r, last_std_r};
        end else if (paddr_i == `CAF_RXEXT_ADDR) begin
            rdata_nxt[17:0] = last_ext_r;
        end else if (paddr_i == `CAF_MATCH_ADDR) begin
            rdata_nxt[15:0] = filter_match_o;
        end
    end

    always @* begin
        match_nxt = 16'h0000;
        for (i = 0; i < `CAF_NUM_FILTERS; i = i + 1) begin
            match_nxt[i] = ctrl_r[`CAF_CTRL_CMP_EN] & filter_hit(std_pattern_r[i],
                ext_pattern_r[i], rx_std_id_i, rx_ext_id_i, rx_id_extended_i,
                ctrl_r[`CAF_CTRL_TYPE_EN]);
        end
    end

    // Patterns have no reset: contents undefined until software writes them
    always @(posedge sys_clk_i) begin
        if (access && pwrite_i && sid_in_block(paddr_i, `CAF_SID_BASE)) begin
            std_pattern_r[idx] <= pwdata_i[15:0] & `CAF_SID_WMASK;
        end
        if (access && pwrite_i && sid_in_block(paddr_i, `CAF_EID_BASE)) begin
            ext_pattern_r[idx] <= pwdata_i[15:0];
        end
    end

    always @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ctrl_r <= `CAF_CTRL_RST;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
            filter_match_o <= 16'h0000;
            match_valid_o <= 1'b0;
            last_std_r <= 11'h000;
            last_ext_r <= 18'h00000;
            last_xtd_r <= 1'b0;
        end else begin
            pready_o <= setup;
            pslverr_o <= setup & ~addr_ok;
            prdata_o <= (setup && !pwrite_i) ? rdata_nxt : 32'h0000_0000;
            if (access && pwrite_i && paddr_i == `CAF_CTRL_ADDR) begin
                ctrl_r <= pwdata_i[1:0];
            end
            match_valid_o <= rx_id_valid_i;
            if (rx_id_valid_i) begin
                filter_match_o <= match_nxt;
                last_std_r <= rx_std_id_i;
                last_ext_r <= rx_ext_id_i;
                last_xtd_r <= rx_id_extended_i;
            end
        end
    end

endmodule
`default_nettype wire

//--- shared/caf_regs.vh
`ifndef CAF_REGS_VH
`define CAF_REGS_VH

// Register map: sixteen filter pairs, each register one aligned word
`define CAF_NUM_FILTERS 16
`define CAF_IDX_W 4
`define CAF_SID_BASE 12'h000
`define CAF_EID_BASE 12'h040
`define CAF_CTRL_ADDR 12'h080
`define CAF_RXSTD_ADDR 12'h084
`define CAF_RXEXT_ADDR 12'h088
`define CAF_MATCH_ADDR 12'h08C
`define CAF_ADDR_W 12
`define CAF_BLOCK_MASK 12'hFC0

// Standard identifier pattern register layout
`define CAF_SID_HI 15
`define CAF_SID_LO 5
`define CAF_SID_TYPE_BIT 3
`define CAF_SID_EXTHI_HI 1
`define CAF_SID_EXTHI_LO 0
`define CAF_SID_WMASK 16'hFFEB

// Control register: bit 0 enables compare, bit 1 enables frame type match
`define CAF_CTRL_CMP_EN 0
`define CAF_CTRL_TYPE_EN 1
`define CAF_CTRL_RST 2'h0

`endif

//--- test/caf_chk_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module caf_chk(input wire sys_clk_i, resetn_i, psel_i, penable_i, pready_o, pslverr_o,
    rx_id_valid_i, match_valid_o, input wire [11:0] paddr_i, input wire [31:0] prdata_o,
    input wire [15:0] filter_match_o);
default clocking cb @(posedge sys_clk_i); endclocking
default disable iff (!resetn_i);
sequence s_mv; ##1 match_valid_o; endsequence
property p_rdy; psel_i && !penable_i |=> pready_o; endproperty
a_rdy: assert property (p_rdy) else $error("no ready");
property p_err; psel_i && !penable_i && (paddr_i > 12'h08C || |paddr_i[1:0]) |=> pslverr_o;
endproperty
a_err: assert property (p_err) else $error("no error");
property p_idl; !pready_o |-> prdata_o == 32'h0; endproperty
a_idl: assert property (p_idl) else $error("idle data");
property p_mv; rx_id_valid_i |-> s_mv; endproperty
a_mv: assert property (p_mv) else $error("no valid");
property p_hld; !rx_id_valid_i |=> $stable(filter_match_o) && !match_valid_o; endproperty
a_hld: assert property (p_hld) else $error("moved");
endmodule
`default_nettype wire

//--- test/caf_rx_model.sv
`timescale 1ns/100ps
`default_nettype none
module caf_rx_model(input wire clk_i, input wire go_i, input wire [29:0] id_i,
    output logic v_o = 1'h0, output logic [29:0] id_o = 30'h0);
always @(posedge clk_i) v_o <= go_i;
always @(posedge clk_i) id_o <= go_i ? id_i : ~id_o; // Idle ids flip, never stale
endmodule
`default_nettype wire

//--- test/caf_filter_ids_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module caf_filter_ids_tb_top;
logic sys_clk_i = 0, resetn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, go = 0;
logic [11:0] paddr_i = 0;
logic [31:0] pwdata_i = 0;
logic [29:0] id = 0;
logic [15:0] s;
wire pready_o, pslverr_o, match_valid_o, rx_id_valid_i, rx_id_extended_i;
wire [31:0] prdata_o;
wire [17:0] rx_ext_id_i;
wire [15:0] filter_match_o;
wire [10:0] rx_std_id_i;
int n_mismatch, check_count, i;
always #20 sys_clk_i = ~sys_clk_i;
caf_filter_ids dut_u(.*);
caf_rx_model rx_u(.clk_i(sys_clk_i), .go_i(go), .id_i(id), .v_o(rx_id_valid_i),
    .id_o({rx_id_extended_i, rx_std_id_i, rx_ext_id_i}));
task stop_test;
    $display("%0d errors %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk(input logic [31:0] g, x);
    check_count++;
    if (g !== x) begin n_mismatch++; $display("[ERR] %0t got %h", $time, g); end
endtask
task apb(input logic w, input logic [11:0] a, input logic [31:0] d, x);
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
    @(posedge sys_clk_i) penable_i <= 1;
    do @(posedge sys_clk_i); while (pready_o !== 1);
    chk({pslverr_o, prdata_o[30:0]}, x);
    {psel_i, penable_i} <= 0;
    @(posedge sys_clk_i);
endtask
task rx(input logic [29:0] v, input logic [15:0] x);
    {go, id} <= {1'h1, v};
    repeat (3) @(posedge sys_clk_i) go <= 0;
    chk({filter_match_o, 15'h0, match_valid_o}, {x, 16'h1});
endtask
initial begin
    repeat (8) @(posedge sys_clk_i);
    resetn_i <= 1;
    for (i = 0; i < 64; i++) begin
        s = i[4] ? {i[3:0], 12'h5A0} : {7'h10, i[3:0], 1'h1, i[0], 3'h6};
        apb(!i[5], {5'h0, i[4:0], 2'h0}, {16'hFFFF, s}, i[5] ? s & 16'hFFEB : 0);
    end
    rx({12'h905, 18'h255A0}, 16'h0);
    apb(1, 12'h080, 32'h1, 0);
    rx({12'h905, 18'h255A0}, 16'h20);
    rx({12'h905, 18'h245A0}, 16'h0);
    rx({12'h905, 18'h275A0}, 16'h0);
    rx({12'h10A, 18'h3FFFF}, 16'h400);
    apb(1, 12'h080, 32'h3, 0);
    rx({12'h10B, 18'h0}, 16'h0);
    rx({12'h90B, 18'h2B5A0}, 16'h800);
    apb(0, 12'h090, 0, 32'h80000000);
    stop_test;
end
initial begin repeat (9000) @(posedge sys_clk_i); n_mismatch++; stop_test; end
endmodule
bind caf_filter_ids caf_chk chk_u(.*);
`default_nettype wire
